// ### ee_regs.svh
// Constants shared by the serial EEPROM target and its controller.
// Assumes a 25 MHz system clock on both ends.
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// System clock rate in MHz
`define EE_CLK_MHZ 25
// Internal write cycle time in ms and in clock cycles
`define EE_TWR_MS 5
`define EE_TWR_CYC (`EE_TWR_MS * `EE_CLK_MHZ * 1000)
// Width of the write cycle counter
`define EE_BUSY_W 17
// Default link clock rate in kHz and its quarter period, rounded up
`define EE_SCL_KHZ 100
`define EE_QTR_RST ((`EE_CLK_MHZ * 1000 + 4 * `EE_SCL_KHZ - 1) / (4 * `EE_SCL_KHZ))

// Fixed prefix of the target address byte
`define EE_PREFIX 4'hA
// Page and array sizes
`define EE_PAGE_BYTES 16
`define EE_MEM_BYTES 256
// Value of an erased byte
`define EE_ERASED 8'hFF

// Controller register offsets
`define EE_CMD_OFS 4'h0
`define EE_STAT_OFS 4'h4
`define EE_QTR_OFS 4'h8
// Command register fields
`define EE_CMD_START 8
`define EE_CMD_READ 9
`define EE_CMD_MACK 10
`define EE_CMD_STOP 11
`define EE_CMD_NOBYTE 12
// Status register fields
`define EE_ST_BUSY 0
`define EE_ST_ACK 1
`define EE_ST_RX_LSB 8
// Width of the quarter period register
`define EE_QTR_W 16
// Bus responses
`define EE_RESP_OK 2'h0
`define EE_RESP_ERR 2'h2

`endif

// ### ee_pkg.sv
// Types shared by the serial EEPROM target and its controller.
// Assumes ee_regs.svh for the numeric constants.
package ee_pkg;

  // Target protocol states
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_ADDR = 3'b001,
    D_WORD = 3'b010,
    D_DATA = 3'b011,
    D_READ = 3'b100,
    D_BUSY = 3'b101
  } ee_dst_e;

  // Controller bit engine states
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_START = 2'b01,
    H_BIT = 2'b10,
    H_STOP = 2'b11
  } ee_hst_e;

  // Register selector of the controller
  typedef enum logic [1:0] {
    R_CMD = 2'b00,
    R_STAT = 2'b01,
    R_QTR = 2'b10,
    R_NONE = 2'b11
  } ee_reg_e;

endpackage

// ### ee_if.sv
// Two-wire link between the EEPROM controller and the EEPROM target.
// Assumes a pull-up: the data wire is high unless an end pulls it low.
`timescale 1ns/1ns
interface ee_if;
  // Link clock, made by the controller
  logic scl;
  // Controller data pin: output and enable
  logic sda_h_o;
  logic sda_h_oe;
  // Target data pin: output and enable
  logic sda_d_o;
  logic sda_d_oe;
  // Resolved wire level
  logic sda;

  // Open-drain wired AND with pull-up
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (output scl, output sda_h_o, output sda_h_oe, input sda);
  modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// ### ee_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes levels that stay put for several clock cycles.
`timescale 1ns/1ns
module ee_sync #(
  parameter int W = 1  // Number of pins
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins in, synchronised levels out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;  // First stage, read only by the second

  // Two stages; resets high, the idle level of the pulled-up link wires,
  // so that no false edge is seen when reset lets go
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '1;
      q <= '1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ### ee_dev.sv
// Serial EEPROM target: two-wire command logic, page buffer and array.
// Assumes a controller on ee_if that makes SCL, START and STOP.
`timescale 1ns/1ns
`include "ee_regs.svh"
module ee_dev
  import ee_pkg::*;
#(
  parameter int WR_CYC = `EE_TWR_CYC  // Internal write cycle length
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Straps and protection
  input wire logic chip_select_bit0,
  input wire logic chip_select_bit1,
  input wire logic chip_select_bit2,
  input wire logic write_protect,
  // Two-wire link
  ee_if.dev link
);
  logic [5:0] pins_s;  // Synchronised link and strap pins
  logic scl_s;  // Link clock level
  logic sda_s;  // Link data level
  logic wp_s;  // Write-protect level
  logic [2:0] cs_s;  // Chip-select straps
  logic scl_q;  // Link clock one cycle late
  logic sda_q;  // Link data one cycle late
  logic rise;  // Link clock rising
  logic fall;  // Link clock falling
  logic start_ev;  // START seen
  logic stop_ev;  // STOP seen
  logic byte_done;  // Falling edge after eighth bit
  logic ack_end;  // Falling edge after ninth bit
  ee_dst_e st_r;  // Protocol state
  logic [3:0] cnt_r;  // Rising edges in this byte
  logic [7:0] sr_r;  // Received byte
  logic [7:0] tx_r;  // Byte being sent
  logic [7:0] ptr_r;  // Address pointer
  logic mack_r;  // Controller acknowledged last read byte
  logic load_r;  // First read byte still to load
  logic first_r;  // Next data byte is the first one
  logic wp_r;  // Write-protect as strobed
  logic oe_r;  // Pulling the data line low
  logic [15:0] pmask_r;  // Buffered page bytes present
  logic [`EE_BUSY_W-1:0] busy_r;  // Write cycle cycles left
  logic addr_hit;  // Address byte selects this target
  logic ack_want;  // Acknowledge the byte just received
  logic wr_take;  // Data byte goes into the page buffer
  logic tx_go;  // Send another read byte
  logic commit;  // STOP would start a write cycle
  logic [2:0] bit_idx;  // Bit of tx_r to present
  // Array starts erased; power-on is the only reset it sees
  logic [7:0] mem [`EE_MEM_BYTES] = '{default: `EE_ERASED};
  logic [7:0] pbuf [`EE_PAGE_BYTES];  // Page write buffer

  // Next address inside the same page
  function automatic logic [7:0] page_inc(input logic [7:0] p);
    page_inc = {p[7:4], p[3:0] + 4'h1};
  endfunction

  // Every pin from outside passes two flops first
  ee_sync #(
    .W(6)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.scl, link.sda, write_protect, chip_select_bit2,
        chip_select_bit1, chip_select_bit0}),
    .q(pins_s)
  );

  assign scl_s = pins_s[5];
  assign sda_s = pins_s[4];
  assign wp_s = pins_s[3];
  assign cs_s = pins_s[2:0];

  // The line is only ever pulled low, never driven high
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = oe_r;

  // Delayed copies for edge and condition detection; idle level is high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  // Link events; data moving while the clock is high marks a condition
  assign rise = scl_s & ~scl_q;
  assign fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev = scl_s & scl_q & ~sda_q & sda_s;
  assign byte_done = fall & (cnt_r == 4'd8);
  assign ack_end = fall & (cnt_r == 4'd9);

  // Decode of the byte in hand
  assign addr_hit = (sr_r[7:4] == `EE_PREFIX) && (sr_r[3:1] == cs_s);
  assign wr_take = byte_done && (st_r == D_DATA) && !(first_r && wp_r);
  assign tx_go = (st_r == D_READ) && (load_r || mack_r);
  assign commit = (st_r == D_DATA) && (pmask_r != 16'h0000);
  assign bit_idx = 3'(4'd7 - cnt_r);

  // Whether the ninth clock of this byte gets an acknowledge
  always_comb begin
    case (st_r)
      D_ADDR: ack_want = addr_hit;
      D_WORD: ack_want = 1'b1;
      D_DATA: ack_want = !(first_r && wp_r);
      default: ack_want = 1'b0;  // Read byte: line released
    endcase
  end

  // Protocol state; the write cycle shuts out every request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= D_IDLE;
      first_r <= 1'b0;
      load_r <= 1'b0;
    end else if (st_r == D_BUSY) begin
      // START and address are ignored, so polling sees no acknowledge
      if (busy_r == '0) begin
        st_r <= D_IDLE;
      end
    end else if (start_ev) begin
      st_r <= D_ADDR;  // Repeated START also lands here
    end else if (stop_ev) begin
      st_r <= commit ? D_BUSY : D_IDLE;
    end else if (byte_done) begin
      case (st_r)
        D_ADDR: begin
          if (!addr_hit) begin
            st_r <= D_IDLE;
          end else if (sr_r[0]) begin
            st_r <= D_READ;
            load_r <= 1'b1;
          end else begin
            st_r <= D_WORD;
          end
        end
        D_WORD: begin
          st_r <= D_DATA;
          first_r <= 1'b1;
        end
        D_DATA: begin
          if (first_r && wp_r) begin
            st_r <= D_IDLE;
          end
          first_r <= 1'b0;
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end else if (ack_end && (st_r == D_READ)) begin
      // Without an acknowledge the read is over; STOP follows
      if (!tx_go) begin
        st_r <= D_IDLE;
      end
      load_r <= 1'b0;
    end
  end

  // Write cycle timer, loaded by the STOP that commits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= '0;
    end else if (stop_ev && commit) begin
      busy_r <= `EE_BUSY_W'(WR_CYC - 1);
    end else if (busy_r != '0) begin
      busy_r <= busy_r - 1'b1;
    end
  end

  // Bit counter within a byte plus acknowledge clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 4'h0;
    end else if (start_ev || stop_ev || ack_end) begin
      cnt_r <= 4'h0;
    end else if (rise && (cnt_r < 4'd9)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // Sample data on the rising edge; ninth bit is the controller's answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_r <= 8'h00;
      mack_r <= 1'b0;
    end else if (rise && (cnt_r < 4'd8)) begin
      sr_r <= {sr_r[6:0], sda_s};
    end else if (rise && (cnt_r == 4'd8)) begin
      mack_r <= ~sda_s;
    end
  end

  // Write-protect strobe at the falling edge before the first data byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r <= 1'b0;
    end else if (ack_end && (st_r == D_DATA) && first_r) begin
      wp_r <= wp_s;
    end
  end

  // Address pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_r <= 8'h00;
    end else if (byte_done && (st_r == D_WORD)) begin
      ptr_r <= sr_r;
    end else if (wr_take) begin
      ptr_r <= page_inc(ptr_r);
    end else if (ack_end && tx_go) begin
      // Full-width count crosses pages; it wraps only past the top
      ptr_r <= ptr_r + 8'h01;
    end
  end

  // Read byte to shift out, fetched as the ninth clock ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_r <= 8'h00;
    end else if (ack_end && tx_go) begin
      tx_r <= mem[ptr_r];
    end
  end

  // Data line drive; changes only while the link clock is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_r <= 1'b0;
    end else if ((st_r == D_BUSY) || start_ev || stop_ev) begin
      oe_r <= 1'b0;
    end else if (byte_done) begin
      oe_r <= ack_want;
    end else if (ack_end) begin
      oe_r <= tx_go ? ~mem[ptr_r][7] : 1'b0;
    end else if (fall && (st_r == D_READ) && (cnt_r != 4'd0)) begin
      oe_r <= ~tx_r[bit_idx];
    end
  end

  // Page presence mask; a new word address empties the buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pmask_r <= 16'h0000;
    end else if (byte_done && (st_r == D_WORD)) begin
      pmask_r <= 16'h0000;
    end else if (wr_take) begin
      pmask_r[ptr_r[3:0]] <= 1'b1;
    end
  end

  // Page buffer; a later byte at the same slot replaces the earlier one
  always_ff @(posedge aclk) begin
    if (wr_take) begin
      pbuf[ptr_r[3:0]] <= sr_r;
    end
  end

  // All buffered bytes go to the array in one cycle at STOP
  always_ff @(posedge aclk) begin
    if (stop_ev && commit) begin
      for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
        if (pmask_r[i]) begin
          mem[{ptr_r[7:4], 4'(i)}] <= pbuf[i];
        end
      end
    end
  end
endmodule

// ### ee_host.sv
// Two-wire EEPROM controller with an AXI4-Lite register port.
// Assumes software sequences bytes; the link clock is made here.
`timescale 1ns/1ns
`include "ee_regs.svh"
module ee_host
  import ee_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [3:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Two-wire link
  ee_if.host link
);
  logic [3:0] awa_r;  // Latched write address
  logic [31:0] wd_r;  // Latched write data
  logic [`EE_QTR_W-1:0] qtr_r;  // Quarter period in clock cycles
  logic [`EE_QTR_W-1:0] div_r;  // Quarter period countdown
  ee_hst_e hst_r;  // Bit engine state
  logic [1:0] step_r;  // Quarter within a bit
  logic [3:0] bit_r;  // Bit within a byte, 8 is acknowledge
  logic [12:0] cmd_r;  // Command in progress
  logic busy_r;  // Command in progress
  logic ack_r;  // Target acknowledged last written byte
  logic [7:0] rx_r;  // Last byte read
  logic scl_r;  // Link clock drive
  logic oe_r;  // Pulling data low
  logic sda_s;  // Synchronised data line
  logic tick;  // Quarter period elapsed
  logic wr_go;  // Both write halves held
  logic cmd_go;  // Command register written while idle

  // Register decode by word offset
  function automatic ee_reg_e reg_sel(input logic [3:0] a);
    if (a == `EE_CMD_OFS) begin
      reg_sel = R_CMD;
    end else if (a == `EE_STAT_OFS) begin
      reg_sel = R_STAT;
    end else if (a == `EE_QTR_OFS) begin
      reg_sel = R_QTR;
    end else begin
      reg_sel = R_NONE;
    end
  endfunction

  // Data line comes back from outside this domain
  ee_sync #(
    .W(1)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link.sda),
    .q(sda_s)
  );

  assign link.scl = scl_r;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe = oe_r;
  assign wr_go = !awready && !wready && !bvalid;
  assign cmd_go = wr_go && (reg_sel(awa_r) == R_CMD) && !busy_r;
  assign tick = (hst_r != H_IDLE) && (div_r == '0);

  // Write channels: each half is held until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `EE_RESP_OK;
      awa_r <= 4'h0;
      wd_r <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        awa_r <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        wd_r <= wdata;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= (reg_sel(awa_r) == R_NONE) ? `EE_RESP_ERR : `EE_RESP_OK;
        awready <= 1'b1;
        wready <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Quarter period register; too small a value outruns the target
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qtr_r <= `EE_QTR_W'(`EE_QTR_RST);
    end else if (wr_go && (reg_sel(awa_r) == R_QTR)) begin
      qtr_r <= wd_r[`EE_QTR_W-1:0];
    end
  end

  // Read channel, answered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `EE_RESP_OK;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `EE_RESP_OK;
      case (reg_sel(araddr))
        R_STAT: rdata <= {16'h0000, rx_r, 6'h00, ack_r, busy_r};
        R_QTR: rdata <= {16'h0000, qtr_r};
        R_CMD: rdata <= 32'h0000_0000;
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `EE_RESP_ERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Quarter period divider, restarted with each command
  always_ff @(posedge aclk) begin
    if (!aresetn || cmd_go || tick) begin
      div_r <= (aresetn && qtr_r != '0) ? qtr_r - 1'b1 : '0;
    end else if (div_r != '0) begin
      div_r <= div_r - 1'b1;
    end
  end

  // Bit engine: START, one byte, acknowledge, STOP
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hst_r <= H_IDLE;
      step_r <= 2'b00;
      bit_r <= 4'h0;
      cmd_r <= 13'h0000;
      busy_r <= 1'b0;
      ack_r <= 1'b0;
      rx_r <= 8'h00;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
    end else if (cmd_go) begin
      cmd_r <= wd_r[12:0];
      busy_r <= 1'b1;
      step_r <= 2'b00;
      bit_r <= 4'h0;
      if (wd_r[`EE_CMD_START]) begin
        hst_r <= H_START;
      end else if (wd_r[`EE_CMD_NOBYTE]) begin
        hst_r <= wd_r[`EE_CMD_STOP] ? H_STOP : H_IDLE;
      end else begin
        hst_r <= H_BIT;
      end
      busy_r <= wd_r[`EE_CMD_START] | ~wd_r[`EE_CMD_NOBYTE]
                | wd_r[`EE_CMD_STOP];
    end else if (tick) begin
      step_r <= step_r + 2'b01;
      case (hst_r)
        H_START: begin
          case (step_r)
            2'b00: oe_r <= 1'b0;
            2'b01: scl_r <= 1'b1;
            2'b10: oe_r <= 1'b1;  // Data falls while clock high
            default: begin
              scl_r <= 1'b0;
              if (!cmd_r[`EE_CMD_NOBYTE]) begin
                hst_r <= H_BIT;
              end else if (cmd_r[`EE_CMD_STOP]) begin
                hst_r <= H_STOP;
              end else begin
                hst_r <= H_IDLE;
                busy_r <= 1'b0;
              end
            end
          endcase
        end
        H_BIT: begin
          case (step_r)
            2'b00: begin
              if (bit_r == 4'd8) begin
                oe_r <= cmd_r[`EE_CMD_READ] & cmd_r[`EE_CMD_MACK];
              end else begin
                oe_r <= ~cmd_r[`EE_CMD_READ] & ~cmd_r[3'(4'd7 - bit_r)];
              end
            end
            2'b01: scl_r <= 1'b1;
            2'b10: begin
              if (bit_r != 4'd8) begin
                rx_r <= {rx_r[6:0], sda_s};
              end else if (!cmd_r[`EE_CMD_READ]) begin
                ack_r <= ~sda_s;
              end
            end
            default: begin
              scl_r <= 1'b0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'd8) begin
                hst_r <= cmd_r[`EE_CMD_STOP] ? H_STOP : H_IDLE;
                busy_r <= cmd_r[`EE_CMD_STOP];
              end
            end
          endcase
        end
        H_STOP: begin
          case (step_r)
            2'b00: oe_r <= 1'b1;
            2'b01: scl_r <= 1'b1;
            2'b10: oe_r <= 1'b0;  // Data rises while clock high
            default: begin
              hst_r <= H_IDLE;
              busy_r <= 1'b0;
            end
          endcase
        end
        default: begin
          busy_r <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ### ee_chk_sva.sv
// Assertions on the two-wire link between controller and target.
// Assumes the ee_if wires, one clock domain, sync active-low reset.
`timescale 1ns/1ns
module ee_chk_sva #(
  parameter int WR_CYC = 125000  // Target write cycle length
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link wires
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe
);
  logic scl_r, sda_r, rd_r, wpend_r;  // Past levels, read, write armed
  logic [1:0] nb_r;  // Byte index, 0 is the address byte
  logic [3:0] bit_r;  // Clock within a byte, 9 is the ack clock
  logic [7:0] sh_r;  // Last byte on the wire
  logic [16:0] busy_r;  // Write cycle left
  wire hi_w = scl & scl_r;
  wire start_w = hi_w & sda_r & ~sda;
  wire stop_w = hi_w & ~sda_r & sda;
  wire rise_w = scl & ~scl_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Past levels for edge detection
  always_ff @(posedge aclk) begin
    scl_r <= scl;
    sda_r <= sda;
  end
  // Clock count, restarted by START
  always_ff @(posedge aclk)
    if (!aresetn || start_w) bit_r <= 4'h0;
    else if (rise_w) bit_r <= (bit_r == 4'h9) ? 4'h1 : bit_r + 4'h1;
  // Ack bit is kept out of the byte
  always_ff @(posedge aclk)
    if (rise_w && bit_r != 4'h8) sh_r <= {sh_r[6:0], sda};
  // Byte index saturates at the first data byte
  always_ff @(posedge aclk)
    if (!aresetn || start_w) nb_r <= 2'h0;
    else if (rise_w && bit_r == 4'h9 && nb_r != 2'h2) nb_r <= nb_r + 2'h1;
  always_ff @(posedge aclk)
    if (!aresetn || start_w) rd_r <= 1'b0;
    else if (rise_w && nb_r == 2'h0 && bit_r == 4'h7) rd_r <= sda;
  // An acknowledged data byte arms the write cycle
  always_ff @(posedge aclk)
    if (!aresetn || start_w) wpend_r <= 1'b0;
    else if (rise_w && bit_r == 4'h8 && nb_r == 2'h2 && !rd_r && !sda)
      wpend_r <= 1'b1;
  // Starts at the wire STOP, a little before the target sees it
  always_ff @(posedge aclk)
    if (!aresetn) busy_r <= 17'h0;
    else if (stop_w && wpend_r) busy_r <= 17'(WR_CYC);
    else if (busy_r != 17'h0) busy_r <= busy_r - 17'h1;
  dev_hold_a: assert property (hi_w |-> $stable(sda_d_oe))
    else $error("target data moved while clock high");
  dev_late_a: assert property ($changed(sda_d_oe) |->
    !scl && !$past(scl, 2)) else $error("target data moved early");
  ack_slot_a: assert property (hi_w && sda_d_oe
    && !(rd_r && nb_r != 2'h0) |-> bit_r == 4'h9)
    else $error("target pulled outside the ack clock");
  rd_free_a: assert property (hi_w && rd_r && nb_r != 2'h0
    && bit_r == 4'h9 |-> !sda_d_oe) else $error("target held read ack");
  prefix_a: assert property (hi_w && nb_r == 2'h0 && bit_r == 4'h9
    && sda_d_oe |-> sh_r[7:4] == 4'hA) else $error("ack to bad prefix");
  host_free_a: assert property (hi_w && bit_r == 4'h9
    && !(rd_r && nb_r != 2'h0) |-> !sda_h_oe)
    else $error("controller drove the ack clock");
  busy_quiet_a: assert property (busy_r != 17'h0 |-> !sda_d_oe)
    else $error("target drove data in write cycle");
  stop_idle_a: assert property (stop_w |=> !sda_d_oe [*8])
    else $error("target drove data after stop");
endmodule

// ### tb_top.sv
// Testbench: software steps the controller, the target answers.
// Assumes ee_host, ee_dev, ee_if and ee_chk_sva.
`timescale 1ns/1ns
`include "ee_regs.svh"
module tb_top;
  import ee_pkg::*;
  localparam int WR = 2000;  // Write cycle, longer than one poll
  // Clock, reset, straps
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic wp = 1'b0;
  logic [2:0] cs = 3'h0;
  // AXI4-Lite master side
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, s;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  // Memory image, pointer, tallies
  int mem[256];
  int ptr = 0, n_mismatch = 0, comparisons = 0, cyc = 0;
  ee_if lnk ();
  ee_host i_ee_host (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .link(lnk.host));
  ee_dev #(.WR_CYC(WR)) i_ee_dev (.aclk(aclk), .aresetn(aresetn),
    .chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
    .chip_select_bit2(cs[2]), .write_protect(wp), .link(lnk.dev));
  ee_chk_sva #(.WR_CYC(WR)) i_chk (.aclk(aclk), .aresetn(aresetn),
    .scl(lnk.scl), .sda(lnk.sda), .sda_h_oe(lnk.sda_h_oe),
    .sda_d_oe(lnk.sda_d_oe));
  initial forever #20 aclk = ~aclk;
  // Hang guard, well above the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Register write; the closing edge keeps the next request clean
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    s = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // One link step, then wait for the controller to go idle
  task automatic op(input logic [4:0] f, input logic [7:0] b);
    axw(`EE_CMD_OFS, {19'h0, f, b});
    do axr(`EE_STAT_OFS); while (s[`EE_ST_BUSY] !== 1'b0);
  endtask
  task automatic wb(input logic [4:0] f, input logic [7:0] b, input logic a);
    op(f, b);
    chk({7'h0, s[`EE_ST_ACK]}, {7'h0, a});
  endtask
  // Read n bytes; a below zero keeps the current pointer
  task automatic rd(input int a, input int n);
    if (a >= 0) begin
      wb(5'h01, {4'hA, cs, 1'b0}, 1'b1);
      wb(5'h00, a[7:0], 1'b1);
      ptr = a;
    end
    wb(5'h01, {4'hA, cs, 1'b1}, 1'b1);
    for (int i = 1; i <= n; i++) begin
      op((i == n) ? 5'h0A : 5'h06, 8'h00);
      chk(s[15:8], mem[ptr][7:0]);
      ptr = (ptr + 1) % 256;
    end
  endtask
  // Write n bytes from a, then poll; p marks a protected write
  task automatic wr(input int a, input int n, input logic p);
    int o;
    logic [7:0] d;
    wb(5'h01, {4'hA, cs, 1'b0}, 1'b1);
    wb(5'h00, a[7:0], 1'b1);
    for (int i = 0; i < n; i++) begin
      o = (a & 8'hF0) | ((a + i) & 4'hF);
      d = 8'($urandom);
      if (!p) mem[o] = d;
      wb((i == n - 1) ? 5'h08 : 5'h00, d, !p);
    end
    if (!p) ptr = (a & 8'hF0) | ((a + n) & 4'hF);
    wb(5'h01, {4'hA, cs, 1'b0}, p);
    op(5'h18, 8'h00);
    if (!p) begin
      repeat (WR) @(posedge aclk);
      wb(5'h01, {4'hA, cs, 1'b0}, 1'b1);
      op(5'h18, 8'h00);
    end
  endtask
  initial begin
    int a;
    foreach (mem[i]) mem[i] = 8'hFF;
    cs <= 3'($urandom(98573));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axw(`EE_QTR_OFS, 32'h8);
    axr(`EE_QTR_OFS);
    chk(s[7:0], 8'h08);
    axw(4'hC, 32'h0);
    chk({6'h0, r}, {6'h0, `EE_RESP_ERR});
    axr(4'hC);
    chk({6'h0, r}, {6'h0, `EE_RESP_ERR});
    a = $urandom % 256;
    rd(a, 2);
    wr(a, 1, 1'b0);
    rd(a, 1);
    wr(a, 18, 1'b0);
    rd(-1, 1);
    rd(a & 8'hF0, 20);
    rd(8'hFD, 4);
    wp <= 1'b1;
    wr(a, 1, 1'b1);
    wp <= 1'b0;
    rd(a, 1);
    for (int i = 0; i < 2; i++) begin
      wb(5'h01, i ? {4'h5, cs, 1'b0} : {4'hA, ~cs, 1'b0}, 1'b0);
      op(5'h18, 8'h00);
    end
    stop_test();
  end
endmodule
